// ---- fcsp_consts.vh ----
// constants for the flash configuration, security and protection registers
// Behaviour
// RQ1: lock bit 10 sets once in user mode, reset clears, test mode writes freely
// RQ2: protection register writable only while lock is zero, always readable
// RQ3: access error enable bit 8 gates access error flag onto interrupt
// RQ4: buffer empty enable bit 7 gates buffer empty flag onto interrupt
// RQ5: command complete enable bit 6 gates done flag onto interrupt
// RQ6: key access bit 5 writable only while backdoor enable is one
// RQ7: key access set routes array writes to key path, else to commands
// RQ8: self branch lock bit 1 sets once; then self branch enable frozen
// RQ9: self branch enable makes busy array reads return A97F
// RQ10: without self branch, busy reads give invalid data, no access error
// RQ11: software disables core interrupts around self branch use
// RQ12: backdoor enable at high bit 15, loaded from flash at reset
// RQ13: security state at high bit 14, one means secured, from code
// RQ14: security registers loaded from stored security words at reset
// RQ15: security registers ignore writes; reserved bits read zero
// RQ16: protected sector blocks program and erase, clear bit permits
// RQ17: sixteen bits map to sixteen 1 KB sectors of 16 KB
// RQ18: protection register loaded from stored protection word at reset
// RQ19: unimplemented sector bits on small variant read zero, read only
// RQ20: protection check only for program, page erase, mass erase commands
// RQ21: software unprotects sector 15 before reprogramming protection word
// RQ22: writing one clears access error flag; zero leaves it
// RQ23: security code binary 10 means secured, others unsecured
// RQ24: configuration resets to zero; reserved bits read zero
`ifndef FCSP_CONSTS_VH
`define FCSP_CONSTS_VH
`define FCSP_OFS_CONFIG      5'h01
`define FCSP_OFS_SEC_HIGH    5'h03
`define FCSP_OFS_SEC_LOW     5'h04
`define FCSP_OFS_PROT        5'h10
`define FCSP_OFS_STATUS      5'h13
`define FCSP_BIT_LOCK        10
`define FCSP_BIT_ACCESS_ERROR_IRQ_ENABLE        8
`define FCSP_BIT_BUFFER_EMPTY_IRQ_ENABLE       7
`define FCSP_BIT_COMMAND_COMPLETE_IRQ_ENABLE        6
`define FCSP_BIT_KEY_ACCESS_MODE      5
`define FCSP_BIT_SBLOCK      1
`define FCSP_BIT_SBEN        0
`define FCSP_BIT_BDEN        15
`define FCSP_BIT_SECST       14
`define FCSP_BIT_ACCESS_ERROR_FLAG      4
`define FCSP_BIT_CBEF        7
`define FCSP_BIT_CCF         6
`define FCSP_CFG_RESET       16'h0000
`define FCSP_CFG_MASK        16'h05E3
`define FCSP_SEC_CODE_ON     2'h2
`define FCSP_BTS_WORD        16'hA97F
`define FCSP_CMD_PGM         7'h20
`define FCSP_CMD_PAGE_ERASE_CMD       7'h40
`define FCSP_CMD_MASS_ERASE_CMD      7'h41
`define FCSP_SMALL_PROT_MASK 16'hFFF0
`define FCSP_FULL_PROT_MASK  16'hFFFF
`endif

// ---- fcsp_sec_decode.v ----
// decode of the two-bit security code into the secured state
module fcsp_sec_decode (
  // code in
  input  wire [1:0] security_code,
  // state out
  output wire       secured
);
`include "fcsp_consts.vh"
  // only one code value locks the part
  assign secured = (security_code == `FCSP_SEC_CODE_ON); // see RQ23
endmodule

// ---- fcsp_prot_check.v ----
// per-sector check of a program or erase against the protection bits
module fcsp_prot_check (
  // command and target
  input  wire [6:0]  cmd,
  input  wire [12:0] word_addr,
  input  wire [15:0] prot,
  // result
  output wire        blocked
);
`include "fcsp_consts.vh"
  wire        is_user_cmd;
  wire        any_prot;
  // 1 KB sector is 512 words: address bits 12:9 give 16 sectors
  assign is_user_cmd = (cmd == `FCSP_CMD_PGM) ||
                       (cmd == `FCSP_CMD_PAGE_ERASE_CMD) ||
                       (cmd == `FCSP_CMD_MASS_ERASE_CMD); // see RQ20
  assign any_prot = |prot;
  // mass erase touches all sectors, so any protected sector stops it
  assign blocked = is_user_cmd &&
                   ((cmd == `FCSP_CMD_MASS_ERASE_CMD) ? any_prot
                    : prot[word_addr[12:9]]); // see RQ16 see RQ17
endmodule

// ---- fcsp_regs.v ----
// configuration, security and protection register bank of the flash
module fcsp_regs #(
  parameter SMALL_ARRAY = 0
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_b,
  // mode
  input  wire        test_mode,
  // register port
  input  wire        reg_sel,
  input  wire        reg_wr,
  input  wire [4:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  // stored configuration words
  input  wire [15:0] stored_protection_word,
  input  wire [15:0] stored_security_low_word,
  input  wire [15:0] stored_security_high_word,
  // command engine status
  input  wire        buffer_empty_flag,
  input  wire        all_commands_done_flag,
  input  wire        access_error_set,
  input  wire        array_busy,
  // array write request
  input  wire        array_wr,
  input  wire [12:0] array_addr,
  input  wire [15:0] array_wdata,
  input  wire [6:0]  array_cmd,
  // array read path
  input  wire        array_rd,
  input  wire [15:0] array_rdata,
  output reg  [15:0] read_data,
  // routed array writes
  output reg         key_write,
  output reg         cmd_start,
  output reg         prot_violation,
  output reg  [15:0] routed_wdata,
  // flag and interrupt
  output reg         access_error_flag,
  output reg         irq
);
`include "fcsp_consts.vh"

  // state machine: load stored words, then run
  localparam ST_LOAD = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [15:0] config_reg;
  reg  [15:0] prot_reg;
  reg  [1:0]  security_code;
  reg         backdoor_enable;
  reg  [15:0] next_config;
  reg  [15:0] rd_mux;
  wire        secured;
  wire        blocked;
  wire        wr_cfg;
  wire        wr_prot;
  wire        wr_stat;
  wire [15:0] prot_mask;
  wire [15:0] sec_high_view;
  wire [15:0] sec_low_view;
  wire        irq_next;

  // implemented sectors; small array lacks the lowest four
  assign prot_mask = SMALL_ARRAY ? `FCSP_SMALL_PROT_MASK
                                 : `FCSP_FULL_PROT_MASK; // see RQ19

  assign wr_cfg  = reg_sel && reg_wr && (reg_addr == `FCSP_OFS_CONFIG);
  assign wr_prot = reg_sel && reg_wr && (reg_addr == `FCSP_OFS_PROT);
  assign wr_stat = reg_sel && reg_wr && (reg_addr == `FCSP_OFS_STATUS);

  fcsp_sec_decode u_dec (
    .security_code (security_code),
    .secured       (secured)
  );

  fcsp_prot_check u_chk (
    .cmd       (array_cmd),
    .word_addr (array_addr),
    .prot      (prot_reg),
    .blocked   (blocked)
  );

  // read-only security views, reserved bits zero
  assign sec_high_view = {backdoor_enable, secured,            // see RQ13
                          14'h0000};                           // see RQ15
  assign sec_low_view  = {14'h0000, security_code};            // see RQ15

  // next state of the sequencer
  always @*
  begin
    next_state = state;
    case (state)
      ST_LOAD: next_state = ST_RUN;
      ST_RUN:  next_state = ST_RUN;
      default: next_state = ST_LOAD;
    endcase
  end

  // next configuration value from a write
  always @*
  begin
    next_config = config_reg;
    if (wr_cfg)
    begin
      next_config[`FCSP_BIT_ACCESS_ERROR_IRQ_ENABLE]  = reg_wdata[`FCSP_BIT_ACCESS_ERROR_IRQ_ENABLE];
      next_config[`FCSP_BIT_BUFFER_EMPTY_IRQ_ENABLE] = reg_wdata[`FCSP_BIT_BUFFER_EMPTY_IRQ_ENABLE];
      next_config[`FCSP_BIT_COMMAND_COMPLETE_IRQ_ENABLE]  = reg_wdata[`FCSP_BIT_COMMAND_COMPLETE_IRQ_ENABLE];
      // lock sets once outside test mode
      if (test_mode)
        next_config[`FCSP_BIT_LOCK] = reg_wdata[`FCSP_BIT_LOCK]; // see RQ1
      else if (reg_wdata[`FCSP_BIT_LOCK])
        next_config[`FCSP_BIT_LOCK] = 1'b1;                      // see RQ1
      if (backdoor_enable)
        next_config[`FCSP_BIT_KEY_ACCESS_MODE] = reg_wdata[`FCSP_BIT_KEY_ACCESS_MODE]; // see RQ6
      // enable judged against the lock held before this write
      if (!config_reg[`FCSP_BIT_SBLOCK])
        next_config[`FCSP_BIT_SBEN] = reg_wdata[`FCSP_BIT_SBEN]; // see RQ8
      if (reg_wdata[`FCSP_BIT_SBLOCK])
        next_config[`FCSP_BIT_SBLOCK] = 1'b1;                    // see RQ8
    end
    next_config = next_config & `FCSP_CFG_MASK;                  // see RQ24
  end

  // register read mux; unmapped offsets read zero
  always @*
  begin
    rd_mux = 16'h0000;
    case (reg_addr)
      `FCSP_OFS_CONFIG:   rd_mux = config_reg;
      `FCSP_OFS_SEC_HIGH: rd_mux = sec_high_view;
      `FCSP_OFS_SEC_LOW:  rd_mux = sec_low_view;
      `FCSP_OFS_PROT:     rd_mux = prot_reg;                     // see RQ2
      `FCSP_OFS_STATUS:
      begin
        rd_mux[`FCSP_BIT_CBEF]   = buffer_empty_flag;
        rd_mux[`FCSP_BIT_CCF]    = all_commands_done_flag;
        rd_mux[`FCSP_BIT_ACCESS_ERROR_FLAG] = access_error_flag;
      end
      default: rd_mux = 16'h0000;
    endcase
  end

  // interrupt request from enabled flags
  assign irq_next =
    (config_reg[`FCSP_BIT_ACCESS_ERROR_IRQ_ENABLE]  && access_error_flag) ||      // see RQ3
    (config_reg[`FCSP_BIT_BUFFER_EMPTY_IRQ_ENABLE] && buffer_empty_flag) ||      // see RQ4
    (config_reg[`FCSP_BIT_COMMAND_COMPLETE_IRQ_ENABLE]  && all_commands_done_flag);   // see RQ5

  // sequencer and stored-word load
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state           <= ST_LOAD;
      security_code   <= 2'h0;
      backdoor_enable <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // words caught after release; security regs never take writes
      if (state == ST_LOAD)
      begin
        security_code   <= stored_security_low_word[1:0];      // see RQ14
        backdoor_enable <= stored_security_high_word[`FCSP_BIT_BDEN]; // see RQ12
      end
    end
  end

  // configuration and protection registers
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      config_reg <= `FCSP_CFG_RESET;                           // see RQ24
      prot_reg   <= 16'h0000;
    end
    else
    begin
      config_reg <= next_config;
      if (state == ST_LOAD)
        prot_reg <= stored_protection_word & prot_mask;        // see RQ18
      else if (wr_prot && !config_reg[`FCSP_BIT_LOCK])
        prot_reg <= reg_wdata & prot_mask;                     // see RQ2
    end
  end

  // access error flag: hardware set wins over software clear
  always @(posedge clk_sys)
  begin
    if (!rst_b)
      access_error_flag <= 1'b0;
    else if (access_error_set)
      access_error_flag <= 1'b1;
    else if (wr_stat && reg_wdata[`FCSP_BIT_ACCESS_ERROR_FLAG])
      access_error_flag <= 1'b0;                               // see RQ22
  end

  // array write routing and protection outcome
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      key_write      <= 1'b0;
      cmd_start      <= 1'b0;
      prot_violation <= 1'b0;
      routed_wdata   <= 16'h0000;
    end
    else
    begin
      key_write      <= array_wr && config_reg[`FCSP_BIT_KEY_ACCESS_MODE]; // see RQ7
      cmd_start      <= array_wr && !config_reg[`FCSP_BIT_KEY_ACCESS_MODE] &&
                        !blocked;                              // see RQ16
      prot_violation <= array_wr && !config_reg[`FCSP_BIT_KEY_ACCESS_MODE] &&
                        blocked;                               // see RQ20
      if (array_wr)
        routed_wdata <= array_wdata;
    end
  end

  // array read path; busy reads never touch the error flag
  always @(posedge clk_sys)
  begin
    if (!rst_b)
      read_data <= 16'h0000;
    else if (array_rd)
    begin
      if (array_busy && config_reg[`FCSP_BIT_SBEN])
        read_data <= `FCSP_BTS_WORD;                           // see RQ9
      else
        read_data <= array_rdata;                              // see RQ10
    end
  end

  // registered outputs
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 16'h0000;
      irq       <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_sel ? rd_mux : 16'h0000;
      irq       <= irq_next;
    end
  end

endmodule

// ---- fcsp_regs_properties.sv ----
// port assertions for the flash register bank
module fcsp_props (
  // clock and reset
  input logic        clk_sys,
  input logic        rst_b,
  // register port
  input logic        reg_sel,
  input logic        reg_wr,
  input logic [4:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata,
  // flags and routing
  input logic        access_error_set,
  input logic        access_error_flag,
  input logic        buffer_empty_flag,
  input logic        all_commands_done_flag,
  input logic        irq,
  input logic        cmd_start,
  input logic        prot_violation
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // decoded reads and the flag clear write
  wire rd_cfg = reg_sel && !reg_wr && reg_addr == 5'h01;
  wire rd_hi  = reg_sel && !reg_wr && reg_addr == 5'h03;
  wire rd_lo  = reg_sel && !reg_wr && reg_addr == 5'h04;
  wire clr    = reg_sel && reg_wr && reg_addr == 5'h13 && reg_wdata[4];
  wire calm   = !(access_error_flag || buffer_empty_flag ||
                  all_commands_done_flag || access_error_set);
  property p_cfg; rd_cfg |=> (reg_rdata & 16'hFA1C) == 16'h0000; endproperty
  a_cfg: assert property (p_cfg)
    else $error("config reserved bit set");
  property p_hi; rd_hi |=> reg_rdata[13:0] == 14'h0000; endproperty
  a_hi: assert property (p_hi)
    else $error("security high reserved bit set");
  property p_lo; rd_lo |=> reg_rdata[15:2] == 14'h0000; endproperty
  a_lo: assert property (p_lo)
    else $error("security low reserved bit set");
  property p_rose; $rose(access_error_flag) |-> $past(access_error_set); endproperty
  a_rose: assert property (p_rose)
    else $error("access error flag set without cause");
  property p_clr; clr && !access_error_set |=> !access_error_flag; endproperty
  a_clr: assert property (p_clr)
    else $error("access error flag not cleared");
  property p_fell; $fell(access_error_flag) |-> $past(clr); endproperty
  a_fell: assert property (p_fell)
    else $error("access error flag dropped without clear");
  property p_calm; calm [*2] |=> !irq; endproperty
  a_calm: assert property (p_calm)
    else $error("interrupt without a flag");
  property p_blk; prot_violation |-> !cmd_start; endproperty
  a_blk: assert property (p_blk)
    else $error("blocked command started");
endmodule
bind fcsp_regs fcsp_props fcsp_props_inst (.clk_sys, .rst_b, .reg_sel,
  .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .access_error_set,
  .access_error_flag, .buffer_empty_flag, .all_commands_done_flag, .irq,
  .cmd_start, .prot_violation);

// ---- fcsp_core_model.sv ----
// processor core model issuing word register accesses
module fcsp_core_model (
  // clock
  input  logic        clk_sys,
  // register port
  output logic        reg_sel,
  output logic        reg_wr,
  output logic [4:0]  reg_addr,
  output logic [15:0] reg_wdata,
  input  logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial
  begin
    reg_sel = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
  end
  // core interrupts stay off, irq is never taken here
  task access(input logic w, input logic [4:0] a, input logic [15:0] d,
              output logic [15:0] q);
    @(posedge clk_sys);
    reg_sel <= 1'b1;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_sel <= 1'b0;
    reg_wdata <= ~d; // released data no longer shows the word
    #1 q = reg_rdata;
  endtask
endmodule

// ---- test_fcsp_regs.sv ----
// self-checking bench for the flash register bank
module test_fcsp_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, rst_b = 1'b0, tm = 1'b0, busy = 1'b0;
  logic        awr = 1'b0, ard = 1'b0, aes = 1'b0, bef = 1'b0, ccf = 1'b0;
  logic        reg_sel, reg_wr, irq, aerr, kw, cs, pv;
  logic [4:0]  reg_addr;
  logic [6:0]  cmd = 7'h00;
  logic [12:0] aadr = 13'h0000;
  logic [15:0] sp = 16'h0000, sh = 16'h0000, sl = 16'h0000;
  logic [15:0] awd = 16'h0000, rdat = 16'h0000;
  logic [15:0] reg_wdata, reg_rdata, rdd, rw, wd, q, rs;
  logic [6:0]  cmds [4] = '{7'h20, 7'h40, 7'h41, 7'h05};
  integer      n_fail = 0, checks = 0, seed = 32'h70E21484, i, k;
  fcsp_regs fcsp_regs_inst (.clk_sys, .rst_b, .test_mode(tm), .reg_sel,
    .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .stored_protection_word(sp), .stored_security_low_word(sl),
    .stored_security_high_word(sh), .buffer_empty_flag(bef),
    .all_commands_done_flag(ccf), .access_error_set(aes),
    .array_busy(busy), .array_wr(awr), .array_addr(aadr),
    .array_wdata(awd), .array_cmd(cmd), .array_rd(ard),
    .array_rdata(rdat), .read_data(rdd), .key_write(kw), .cmd_start(cs),
    .prot_violation(pv), .routed_wdata(rw), .access_error_flag(aerr),
    .irq);
  fcsp_core_model fcsp_core_model_inst (.clk_sys, .reg_sel, .reg_wr,
    .reg_addr, .reg_wdata, .reg_rdata);
  // smaller array variant on the same bus; only its read data is watched
  fcsp_regs #(.SMALL_ARRAY(1)) fcsp_regs_small_inst (.clk_sys, .rst_b,
    .test_mode(tm), .reg_sel, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata(rs), .stored_protection_word(sp),
    .stored_security_low_word(sl), .stored_security_high_word(sh),
    .buffer_empty_flag(bef), .all_commands_done_flag(ccf),
    .access_error_set(aes), .array_busy(busy), .array_wr(awr),
    .array_addr(aadr), .array_wdata(awd), .array_cmd(cmd), .array_rd(ard),
    .array_rdata(rdat), .read_data(), .key_write(), .cmd_start(),
    .prot_violation(), .routed_wdata(), .access_error_flag(), .irq());
  // 100 MHz clock
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input logic [15:0] g, e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e);
    fcsp_core_model_inst.access(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    fcsp_core_model_inst.access(1'b1, a, d, q);
  endtask
  // one array access; pulses looked at in the cycle they stand
  task arr(input logic w, b, input logic [6:0] c, input logic [12:0] a);
    @(posedge clk_sys);
    awr <= w;
    ard <= !w;
    busy <= b;
    cmd <= c;
    aadr <= a;
    awd <= $random(seed);
    rdat <= $random(seed);
    @(posedge clk_sys);
    awr <= 1'b0;
    ard <= 1'b0;
    #1;
  endtask
  // engine flags; irq lags a flag by one cycle, an access error set by two
  task fl(input logic b, c, e);
    @(posedge clk_sys);
    bef <= b;
    ccf <= c;
    aes <= e;
    @(posedge clk_sys);
    aes <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  function logic blk(input logic [6:0] c, input logic [15:0] p);
    if (c == 7'h41)
      blk = |p;
    else
      blk = (c == 7'h20 || c == 7'h40) && p[aadr[12:9]];
  endfunction
  task results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one reset per security code value
  initial
  begin
    for (i = 0; i < 4; i++)
    begin
      wd = $random(seed);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      sp <= $random(seed);
      sh <= $random(seed);
      sl <= {wd[15:2], i[1:0]};
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rd(5'h01, 16'h0000);
      rd(5'h10, sp);
      chk(rs, sp & 16'hFFF0);
      for (k = 0; k < 2; k++)
      begin
        rd(5'h03, {sh[15], sl[1:0] == 2'h2, 14'h0000});
        rd(5'h04, {14'h0000, sl[1:0]});
        wr(5'h03, 16'hFFFF);
        wr(5'h04, 16'hFFFF);
      end
      wd = $random(seed);
      wr(5'h10, wd);
      rd(5'h10, wd);
      chk(rs, wd & 16'hFFF0);
      arr(1'b0, 1'b1, 7'h00, 13'h0000);
      chk(rdd, rdat);
      chk(aerr, 1'b0);
      for (k = 0; k < 4; k++)
      begin
        arr(1'b1, 1'b0, cmds[k], $random(seed));
        chk(pv, blk(cmds[k], wd));
        chk(rw, awd);
        if (k < 3)
          chk(cs, !blk(cmds[k], wd));
      end
      wr(5'h10, wd & 16'h7FFF);
      arr(1'b1, 1'b0, 7'h20, 13'h1FFA);
      chk(cs, 1'b1);
      wr(5'h01, 16'hFFFF);
      rd(5'h01, 16'h05C3 | {10'h000, sh[15], 5'h00});
      wr(5'h10, ~wd);
      rd(5'h10, wd & 16'h7FFF);
      arr(1'b0, 1'b1, 7'h00, 13'h0000);
      chk(rdd, 16'hA97F);
      arr(1'b1, 1'b0, 7'h20, 13'h0000);
      chk(kw, sh[15]);
      fl(1'b1, 1'b0, 1'b0);
      chk(irq, 1'b1);
      fl(1'b0, 1'b1, 1'b0);
      chk(irq, 1'b1);
      fl(1'b0, 1'b0, 1'b1);
      chk(irq, 1'b1);
      wr(5'h13, 16'h0000);
      chk(aerr, 1'b1);
      wr(5'h01, 16'h0000);
      rd(5'h01, 16'h0403);
      fl(1'b1, 1'b1, 1'b0);
      chk(irq, 1'b0);
      wr(5'h13, 16'h0010);
      chk(aerr, 1'b0);
      @(posedge clk_sys);
      tm <= 1'b1;
      wr(5'h01, 16'h0000);
      rd(5'h01, 16'h0003);
      @(posedge clk_sys);
      tm <= 1'b0;
      fl(1'b0, 1'b0, 1'b0);
      $display("pass %0d done", i);
    end
    results;
  end
  // watchdog: the four passes need under 400 cycles, far below its 20000
  initial
  begin
    #200000;
    n_fail++;
    results;
  end
endmodule
